// [common/sbf_defs.svh]
/*
 * constants of the system bus fabric: memory map, register word indices,
 * identity words and reset values.
 * assumes inclusion by the fabric and the bench only.
 */
`ifndef SBF_DEFS_SVH
`define SBF_DEFS_SVH

// ************************************
// memory map
// ************************************
`define SBF_REG_BASE 32'h0000_0000
`define SBF_REG_LAST 32'h0000_001F
`define SBF_SRAM1_BASE 32'h0200_0000
`define SBF_SRAM1_LAST 32'h021F_FFFF
`define SBF_SRAM2_BASE 32'h0400_0000
`define SBF_SRAM2_LAST 32'h041F_FFFF
`define SBF_UNAT_BASE 32'h4000_0000
`define SBF_UNAT_LAST 32'h7FFF_FFFF
`define SBF_UWB_BASE 32'h8000_0000
`define SBF_UWB_LAST 32'hFFFF_FFFF

// ************************************
// register word indices
// ************************************
`define SBF_W_CARD_ID 4'h0
`define SBF_W_SIGNATURE 4'h1
`define SBF_W_BUILD 4'h2
`define SBF_W_SCRATCH 4'h3
`define SBF_W_CLK_CTRL 4'h4
`define SBF_W_RELOAD 4'h5
`define SBF_W_EXT_FLAGS 4'h6
`define SBF_W_SPARE 4'h7
`define SBF_W_MEM_CTRL 4'h8
`define SBF_W_MEM_FLAGS 4'h9
`define SBF_W_SYN_TX 4'hA
`define SBF_W_SYN_SETUP 4'hB
`define SBF_W_SYN_RX 4'hC
`define SBF_W_TW_SETUP 4'hD
`define SBF_W_TW_REQ 4'hE
`define SBF_W_TW_RESP 4'hF

// ************************************
// reset values and identity words (arbitrary values)
// ************************************
`define SBF_RW_RESET 32'h0000_0000
`define SBF_CARD_CHARS 32'h5442_4F41
`define SBF_SIG_CHARS 32'h7362_3278
`define SBF_BUILD_WORD 32'h1010_0021
`define SBF_SPARE_VALUE 32'h0000_0000
`define SBF_RD_UNMAPPED 32'h0000_0000

`endif

// [common/sbf_pkg.sv]
/*
 * types shared by the system bus fabric.
 * assumes it is compiled ahead of every file that names its types.
 */
package sbf_pkg;
   // arbiter ownership state
   typedef enum logic [1:0] {
      SBF_IDLE,
      SBF_OWN0,
      SBF_OWN1
   } sbf_owner_e;

   // slave selected by address decode
   typedef enum logic [2:0] {
      SBF_SEL_REGS,
      SBF_SEL_SRAM1,
      SBF_SEL_SRAM2,
      SBF_SEL_UNAT,
      SBF_SEL_UWB,
      SBF_SEL_NONE
   } sbf_sel_e;
endpackage

// [rtl/sbf_fabric.sv]
/*
 * system bus fabric: two-master arbiter, address decoder, register bank.
 * assumes both masters and all slaves share clk_in (the 40 mhz bus clock)
 * and that external slaves keep the strobe/ack rules themselves.
 */
`include "sbf_defs.svh"

module sbf_fabric (
   // clock, reset, enable
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire logic ce_in,
   // master 0
   input wire logic m0_stb_in,
   input wire logic m0_we_in,
   input wire logic [31:0] m0_addr_in,
   input wire logic [31:0] m0_wdata_in,
   output logic m0_ack_out,
   output logic m0_err_out,
   output logic [31:0] m0_rdata_out,
   // master 1
   input wire logic m1_stb_in,
   input wire logic m1_we_in,
   input wire logic [31:0] m1_addr_in,
   input wire logic [31:0] m1_wdata_in,
   output logic m1_ack_out,
   output logic m1_err_out,
   output logic [31:0] m1_rdata_out,
   // shared slave request, one strobe per slave
   output logic [31:0] s_addr_out,
   output logic [31:0] s_wdata_out,
   output logic s_we_out,
   output logic sram1_stb_out,
   output logic sram2_stb_out,
   output logic unat_stb_out,
   output logic uwb_stb_out,
   // slave answers
   input wire logic sram1_ack_in,
   input wire logic [31:0] sram1_rdata_in,
   input wire logic sram2_ack_in,
   input wire logic [31:0] sram2_rdata_in,
   input wire logic unat_ack_in,
   input wire logic [31:0] unat_rdata_in,
   input wire logic uwb_ack_in,
   input wire logic [31:0] uwb_rdata_in,
   // register bank side signals
   input wire logic [31:0] ext_flags_in,
   input wire logic [31:0] mem_flags_in,
   input wire logic [31:0] syn_rx_in,
   input wire logic [31:0] tw_resp_in,
   output logic [31:0] clk_ctrl_out,
   output logic [31:0] reload_ctrl_out,
   output logic [31:0] mem_ctrl_out,
   output logic [31:0] syn_tx_out,
   output logic [31:0] syn_setup_out,
   output logic [31:0] tw_setup_out,
   output logic [31:0] tw_req_out
);

   // ************************************
   // decode
   // ************************************
   function automatic sbf_pkg::sbf_sel_e decode(input logic [31:0] a);
      sbf_pkg::sbf_sel_e s;
      s = sbf_pkg::SBF_SEL_NONE;
      if (a <= `SBF_REG_LAST) begin
         s = sbf_pkg::SBF_SEL_REGS;
      end else if (a >= `SBF_SRAM1_BASE && a <= `SBF_SRAM1_LAST) begin
         s = sbf_pkg::SBF_SEL_SRAM1;
      end else if (a >= `SBF_SRAM2_BASE && a <= `SBF_SRAM2_LAST) begin
         s = sbf_pkg::SBF_SEL_SRAM2;
      end else if (a >= `SBF_UNAT_BASE && a <= `SBF_UNAT_LAST) begin
         s = sbf_pkg::SBF_SEL_UNAT;
      end else if (a >= `SBF_UWB_BASE) begin
         s = sbf_pkg::SBF_SEL_UWB;
      end
      return s;
   endfunction

   // ************************************
   // arbiter
   // ************************************
   sbf_pkg::sbf_owner_e owner_r;
   sbf_pkg::sbf_owner_e owner_nxt;
   logic last1_r;
   logic stb;
   logic ack;

   // owner holds the bus while its strobe stays up; round robin on ties
   always_comb begin
      owner_nxt = owner_r;
      case (owner_r)
         sbf_pkg::SBF_IDLE: begin
            if (m0_stb_in && (!m1_stb_in || last1_r)) begin
               owner_nxt = sbf_pkg::SBF_OWN0;
            end else if (m1_stb_in) begin
               owner_nxt = sbf_pkg::SBF_OWN1;
            end
         end
         sbf_pkg::SBF_OWN0: begin
            if (!m0_stb_in) begin
               owner_nxt = sbf_pkg::SBF_IDLE;
            end
         end
         sbf_pkg::SBF_OWN1: begin
            if (!m1_stb_in) begin
               owner_nxt = sbf_pkg::SBF_IDLE;
            end
         end
         default: owner_nxt = sbf_pkg::SBF_IDLE;
      endcase
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         owner_r <= sbf_pkg::SBF_IDLE;
      end else if (ce_in) begin
         owner_r <= owner_nxt;
      end
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         last1_r <= 1'b0;
      end else if (ce_in && owner_r == sbf_pkg::SBF_IDLE
                   && owner_nxt != sbf_pkg::SBF_IDLE) begin
         last1_r <= (owner_nxt == sbf_pkg::SBF_OWN1);
      end
   end

   // ************************************
   // routing
   // ************************************
   sbf_pkg::sbf_sel_e sel;
   logic reg_ack;
   logic [31:0] reg_rdata;
   logic [31:0] rdata;

   // the first grant costs one cycle; back to back cycles then pass freely
   always_comb begin
      stb = 1'b0;
      s_we_out = 1'b0;
      s_addr_out = 32'h0000_0000;
      s_wdata_out = 32'h0000_0000;
      case (owner_r)
         sbf_pkg::SBF_OWN0: begin
            stb = m0_stb_in;
            s_we_out = m0_we_in;
            s_addr_out = m0_addr_in;
            s_wdata_out = m0_wdata_in;
         end
         sbf_pkg::SBF_OWN1: begin
            stb = m1_stb_in;
            s_we_out = m1_we_in;
            s_addr_out = m1_addr_in;
            s_wdata_out = m1_wdata_in;
         end
         default: stb = 1'b0;
      endcase
   end

   assign sel = decode(s_addr_out);
   assign sram1_stb_out = stb && sel == sbf_pkg::SBF_SEL_SRAM1;
   assign sram2_stb_out = stb && sel == sbf_pkg::SBF_SEL_SRAM2;
   assign unat_stb_out = stb && sel == sbf_pkg::SBF_SEL_UNAT;
   assign uwb_stb_out = stb && sel == sbf_pkg::SBF_SEL_UWB;

   // unmapped holes answer at once with err so the master never hangs
   always_comb begin
      ack = 1'b0;
      rdata = `SBF_RD_UNMAPPED;
      case (sel)
         sbf_pkg::SBF_SEL_REGS: begin
            ack = reg_ack;
            rdata = reg_rdata;
         end
         sbf_pkg::SBF_SEL_SRAM1: begin
            ack = sram1_ack_in && stb;
            rdata = sram1_rdata_in;
         end
         sbf_pkg::SBF_SEL_SRAM2: begin
            ack = sram2_ack_in && stb;
            rdata = sram2_rdata_in;
         end
         sbf_pkg::SBF_SEL_UNAT: begin
            ack = unat_ack_in && stb;
            rdata = unat_rdata_in;
         end
         sbf_pkg::SBF_SEL_UWB: begin
            ack = uwb_ack_in && stb;
            rdata = uwb_rdata_in;
         end
         default: ack = 1'b0;
      endcase
   end

   logic err;
   assign err = stb && sel == sbf_pkg::SBF_SEL_NONE;

   assign m0_ack_out = ack && owner_r == sbf_pkg::SBF_OWN0;
   assign m1_ack_out = ack && owner_r == sbf_pkg::SBF_OWN1;
   assign m0_err_out = err && owner_r == sbf_pkg::SBF_OWN0;
   assign m1_err_out = err && owner_r == sbf_pkg::SBF_OWN1;
   assign m0_rdata_out = rdata;
   assign m1_rdata_out = rdata;

   // ************************************
   // register bank
   // ************************************
   logic reg_stb;
   logic reg_wr;
   logic [3:0] widx;

   assign reg_stb = stb && sel == sbf_pkg::SBF_SEL_REGS;
   assign reg_ack = reg_stb;
   assign widx = s_addr_out[3:0];
   assign reg_wr = reg_stb && s_we_out && ce_in;

   logic [31:0] scratch_r;
   logic [31:0] clk_ctrl_r;
   logic [31:0] reload_r;
   logic [31:0] mem_ctrl_r;
   logic [31:0] syn_tx_r;
   logic [31:0] syn_setup_r;
   logic [31:0] tw_setup_r;
   logic [31:0] tw_req_r;

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         scratch_r <= `SBF_RW_RESET;
         clk_ctrl_r <= `SBF_RW_RESET;
         reload_r <= `SBF_RW_RESET;
         mem_ctrl_r <= `SBF_RW_RESET;
         syn_tx_r <= `SBF_RW_RESET;
         syn_setup_r <= `SBF_RW_RESET;
         tw_setup_r <= `SBF_RW_RESET;
         tw_req_r <= `SBF_RW_RESET;
      end else if (reg_wr) begin
         case (widx)
            `SBF_W_SCRATCH: scratch_r <= s_wdata_out;
            `SBF_W_CLK_CTRL: clk_ctrl_r <= s_wdata_out;
            `SBF_W_RELOAD: reload_r <= s_wdata_out;
            `SBF_W_MEM_CTRL: mem_ctrl_r <= s_wdata_out;
            `SBF_W_SYN_TX: syn_tx_r <= s_wdata_out;
            `SBF_W_SYN_SETUP: syn_setup_r <= s_wdata_out;
            `SBF_W_TW_SETUP: tw_setup_r <= s_wdata_out;
            `SBF_W_TW_REQ: tw_req_r <= s_wdata_out;
            default: scratch_r <= scratch_r;
         endcase
      end
   end

   // read-only words ignore writes but still ack
   always_comb begin
      case (widx)
         `SBF_W_CARD_ID: reg_rdata = `SBF_CARD_CHARS;
         `SBF_W_SIGNATURE: reg_rdata = `SBF_SIG_CHARS;
         `SBF_W_BUILD: reg_rdata = `SBF_BUILD_WORD;
         `SBF_W_SCRATCH: reg_rdata = scratch_r;
         `SBF_W_CLK_CTRL: reg_rdata = clk_ctrl_r;
         `SBF_W_RELOAD: reg_rdata = reload_r;
         `SBF_W_EXT_FLAGS: reg_rdata = ext_flags_in;
         `SBF_W_SPARE: reg_rdata = `SBF_SPARE_VALUE;
         `SBF_W_MEM_CTRL: reg_rdata = mem_ctrl_r;
         `SBF_W_MEM_FLAGS: reg_rdata = mem_flags_in;
         `SBF_W_SYN_TX: reg_rdata = syn_tx_r;
         `SBF_W_SYN_SETUP: reg_rdata = syn_setup_r;
         `SBF_W_SYN_RX: reg_rdata = syn_rx_in;
         `SBF_W_TW_SETUP: reg_rdata = tw_setup_r;
         `SBF_W_TW_REQ: reg_rdata = tw_req_r;
         `SBF_W_TW_RESP: reg_rdata = tw_resp_in;
         default: reg_rdata = `SBF_RD_UNMAPPED;
      endcase
   end

   assign clk_ctrl_out = clk_ctrl_r;
   assign reload_ctrl_out = reload_r;
   assign mem_ctrl_out = mem_ctrl_r;
   assign syn_tx_out = syn_tx_r;
   assign syn_setup_out = syn_setup_r;
   assign tw_setup_out = tw_setup_r;
   assign tw_req_out = tw_req_r;

   // ************************************
   // checks
   // ************************************
   property p_one_owner;
      @(posedge clk_in) disable iff (!arst_n_in)
      !(m0_ack_out && m1_ack_out);
   endproperty
   a_single_grant: assert property (p_one_owner)
      else $error("both masters acked");

   a_ack_with_stb: assert property (@(posedge clk_in)
      disable iff (!arst_n_in) (m0_ack_out |-> m0_stb_in))
      else $error("ack without strobe");

   a_m1_ack_stb: assert property (@(posedge clk_in)
      disable iff (!arst_n_in) (m1_ack_out |-> m1_stb_in))
      else $error("master 1 ack without strobe");

   a_reg_zero_wait: assert property (@(posedge clk_in)
      disable iff (!arst_n_in) reg_stb |-> (m0_ack_out || m1_ack_out))
      else $error("register bank did not ack at once");

   a_one_strobe: assert property (@(posedge clk_in)
      disable iff (!arst_n_in)
      $onehot0({sram1_stb_out, sram2_stb_out, unat_stb_out,
                uwb_stb_out, reg_stb}))
      else $error("more than one slave strobed");

   a_reg_map: assert property (@(posedge clk_in)
      disable iff (!arst_n_in)
      (stb && s_addr_out[31:5] == 27'h000_0000) |-> reg_stb)
      else $error("register window missed");

   a_sram1_map: assert property (@(posedge clk_in)
      disable iff (!arst_n_in)
      (stb && s_addr_out[31:21] == 11'h010) |-> sram1_stb_out)
      else $error("sram1 window missed");

   a_sram2_map: assert property (@(posedge clk_in)
      disable iff (!arst_n_in)
      (stb && s_addr_out[31:21] == 11'h020) |-> sram2_stb_out)
      else $error("sram2 window missed");

   a_wb_map: assert property (@(posedge clk_in)
      disable iff (!arst_n_in)
      (stb && s_addr_out[31]) |-> uwb_stb_out)
      else $error("wishbone window missed");

   a_unat_map: assert property (@(posedge clk_in)
      disable iff (!arst_n_in)
      (stb && s_addr_out[31:30] == 2'b01) |-> unat_stb_out)
      else $error("native user window missed");

   // the hole between the register window and sram1 must end with err, never hang the master
   a_hole_err: assert property (@(posedge clk_in)
      disable iff (!arst_n_in)
      (stb && s_addr_out[31:25] == 7'h00 && s_addr_out[24:5] != 20'h0_0000)
      |-> (m0_err_out || m1_err_out))
      else $error("unmapped address not refused");

   sequence s_m0_served;
      m0_ack_out ##1 m0_stb_in;
   endsequence
   a_grant_kept: assert property (@(posedge clk_in)
      disable iff (!arst_n_in) s_m0_served |-> !m1_ack_out)
      else $error("bus taken from a master that kept strobe");

   sequence s_scratch_write;
      reg_wr && widx == `SBF_W_SCRATCH;
   endsequence
   a_scratch_back: assert property (@(posedge clk_in)
      disable iff (!arst_n_in)
      s_scratch_write |=> scratch_r == $past(s_wdata_out))
      else $error("scratch word lost write");

   a_card_id: assert property (@(posedge clk_in)
      disable iff (!arst_n_in)
      (reg_stb && widx == `SBF_W_CARD_ID)
      |-> rdata == `SBF_CARD_CHARS)
      else $error("card id wrong");
endmodule

// [test/sbf_slave_model.sv]
/*
 * behavioural slave for one external window of the fabric, answering
 * after a fixed number of wait states.
 * assumes strobe and address come straight from the fabric.
 */
module sbf_slave_model #(
   parameter int WAIT = 0
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic arst_n_in,
   // request
   input wire logic stb_in,
   input wire logic [31:0] addr_in,
   // answer
   output logic ack_out,
   output logic [31:0] rdata_out
);
   timeunit 1ns;
   timeprecision 100ps;
   // ************************************
   // wait counter and answer
   // ************************************
   logic [3:0] wait_r;
   logic [31:0] junk_r;

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wait_r <= 4'h0;
      end else if (!stb_in || ack_out) begin
         wait_r <= 4'h0;
      end else begin
         wait_r <= wait_r + 4'h1;
      end
   end

   // idle data changes every cycle so a stale read never matches
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         junk_r <= 32'h0000_0000;
      end else begin
         junk_r <= junk_r + 32'h9E37_79B9;
      end
   end

   // gated by strobe: ack falls in the cycle strobe falls
   assign ack_out = stb_in && (wait_r == WAIT[3:0]);
   assign rdata_out = ack_out ? ~addr_in : junk_r;
endmodule

// [test/testbench.sv]
/*
 * self-checking bench of the system bus fabric: two masters, register
 * bank, address decode, arbitration and back-to-back cycles.
 * assumes sbf_defs.svh on the include path and the slave model.
 */
`include "sbf_defs.svh"
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   // ************************************
   // signals
   // ************************************
   logic clk_in, arst_n_in, ce_in;
   logic m0_stb_in, m0_we_in, m1_stb_in, m1_we_in;
   logic [31:0] m0_addr_in, m0_wdata_in, m1_addr_in, m1_wdata_in;
   logic m0_ack_out, m0_err_out, m1_ack_out, m1_err_out, s_we_out;
   logic [31:0] m0_rdata_out, m1_rdata_out, s_addr_out, s_wdata_out;
   logic sram1_stb_out, sram2_stb_out, unat_stb_out, uwb_stb_out;
   logic sram1_ack_in, sram2_ack_in, unat_ack_in, uwb_ack_in;
   logic [31:0] sram1_rdata_in, sram2_rdata_in, unat_rdata_in, uwb_rdata_in;
   logic [31:0] ext_flags_in, mem_flags_in, syn_rx_in, tw_resp_in;
   logic [31:0] clk_ctrl_out, reload_ctrl_out, mem_ctrl_out, syn_tx_out;
   logic [31:0] syn_setup_out, tw_setup_out, tw_req_out, cap_wd;
   logic [3:0] sel_seen;
   logic cap_we;
   int err_total, compares;

   sbf_fabric i_dut (.*);
   sbf_slave_model #(.WAIT(0)) i_sram1 (.clk_in, .arst_n_in,
      .stb_in(sram1_stb_out), .addr_in(s_addr_out),
      .ack_out(sram1_ack_in), .rdata_out(sram1_rdata_in));
   sbf_slave_model #(.WAIT(2)) i_sram2 (.clk_in, .arst_n_in,
      .stb_in(sram2_stb_out), .addr_in(s_addr_out),
      .ack_out(sram2_ack_in), .rdata_out(sram2_rdata_in));
   sbf_slave_model #(.WAIT(1)) i_unat (.clk_in, .arst_n_in,
      .stb_in(unat_stb_out), .addr_in(s_addr_out),
      .ack_out(unat_ack_in), .rdata_out(unat_rdata_in));
   sbf_slave_model #(.WAIT(3)) i_uwb (.clk_in, .arst_n_in,
      .stb_in(uwb_stb_out), .addr_in(s_addr_out),
      .ack_out(uwb_ack_in), .rdata_out(uwb_rdata_in));

   // ************************************
   // helpers
   // ************************************
   task automatic chk(input logic [31:0] got, exp, input string s);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("Error %0t: %s got %h exp %h", $time, s, got, exp);
      end
   endtask

   task automatic end_sim();
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // entered just after a rising edge; keep leaves strobe up for the next
   task automatic bus(input bit m, input logic w, input logic [31:0] a, d,
         input bit keep, output logic [31:0] q, output logic e);
      int n = 0;
      sel_seen = 4'h0;
      if (m) begin
         m1_stb_in <= 1'b1;
         m1_we_in <= w;
         m1_addr_in <= a;
         m1_wdata_in <= d;
      end else begin
         m0_stb_in <= 1'b1;
         m0_we_in <= w;
         m0_addr_in <= a;
         m0_wdata_in <= d;
      end
      do begin
         @(negedge clk_in);
         n++;
      end while (!(m ? (m1_ack_out | m1_err_out) : (m0_ack_out | m0_err_out))
                 && n < 40);
      q = m ? m1_rdata_out : m0_rdata_out;
      e = m ? m1_err_out : m0_err_out;
      if (n >= 40) chk(32'h0, 32'h1, "no answer");
      @(posedge clk_in);
      if (!keep) begin
         if (m) m1_stb_in <= 1'b0;
         else m0_stb_in <= 1'b0;
         @(posedge clk_in);
      end
   endtask

   task automatic rd(input bit m, input logic [31:0] a, exp, input string s);
      logic [31:0] q;
      logic e;
      bus(m, 1'b0, a, 32'h0, 1'b0, q, e);
      chk(q, exp, s);
   endtask

   task automatic wr(input bit m, input logic [31:0] a, d);
      logic [31:0] q;
      logic e;
      bus(m, 1'b1, a, d, 1'b0, q, e);
      chk({31'h0, e}, 32'h0, "write refused");
   endtask

   function automatic logic [31:0] port_of(input logic [3:0] w);
      case (w)
         4'h4: return clk_ctrl_out;
         4'h5: return reload_ctrl_out;
         4'h8: return mem_ctrl_out;
         4'hA: return syn_tx_out;
         4'hB: return syn_setup_out;
         4'hD: return tw_setup_out;
         default: return tw_req_out;
      endcase
   endfunction

   // watch every cycle for overlapping grants and stray acks
   always @(negedge clk_in) begin
      sel_seen |= {uwb_stb_out, unat_stb_out, sram2_stb_out, sram1_stb_out};
      if (sram1_stb_out | sram2_stb_out | unat_stb_out | uwb_stb_out) begin
         cap_wd = s_wdata_out;
         cap_we = s_we_out;
      end
      if (m0_ack_out & m1_ack_out) chk(32'h1, 32'h0, "two acks");
      if ((m0_ack_out & !m0_stb_in) | (m1_ack_out & !m1_stb_in))
         chk(32'h1, 32'h0, "ack without strobe");
   end

   // ************************************
   // scenarios
   // ************************************
   task automatic t_ids();
      rd(0, 32'h0, `SBF_CARD_CHARS, "card id");
      rd(1, 32'h1, `SBF_SIG_CHARS, "signature");
      rd(0, 32'h2, `SBF_BUILD_WORD, "build");
      rd(1, 32'h3, `SBF_RW_RESET, "scratch reset");
      rd(0, 32'h6, ext_flags_in, "ext flags");
      rd(1, 32'h7, `SBF_SPARE_VALUE, "spare");
      rd(0, 32'h9, mem_flags_in, "mem flags");
      rd(1, 32'hC, syn_rx_in, "synth rx");
      rd(0, 32'hF, tw_resp_in, "two-wire reply");
      wr(0, 32'h0, 32'hFFFF_FFFF);
      rd(0, 32'h0, `SBF_CARD_CHARS, "card after write");
      wr(1, 32'h6, 32'h0000_0000);
      rd(1, 32'h6, ext_flags_in, "flags after write");
      rd(0, 32'h12, `SBF_BUILD_WORD, "upper alias");
      rd(1, 32'h1F, tw_resp_in, "last word");
      $display("t_ids done at %0t", $time);
   endtask

   task automatic t_rw();
      logic [3:0] ws[8] = '{4'h3, 4'h4, 4'h5, 4'h8, 4'hA, 4'hB, 4'hD, 4'hE};
      foreach (ws[i]) wr(i[0], {28'h0, ws[i]}, {4{ws[i], 4'h6}});
      foreach (ws[i]) begin
         rd(~i[0], {28'h0, ws[i]}, {4{ws[i], 4'h6}}, "readback");
         if (ws[i] != 4'h3)
            chk(port_of(ws[i]), {4{ws[i], 4'h6}}, "ctrl out");
      end
      $display("t_rw done at %0t", $time);
   endtask

   task automatic t_decode();
      logic [31:0] ad[8] = '{32'h0200_0000, 32'h021F_FFFF, 32'h0400_0000,
         32'h041F_FFFF, 32'h4000_0000, 32'h7FFF_FFFF, 32'h8000_0000,
         32'hFFFF_FFFF};
      logic [31:0] bad[3] = '{32'h0000_0020, 32'h0220_0000, 32'h3FFF_FFFF};
      logic [31:0] q;
      logic e;
      foreach (ad[i]) begin
         bus(i[0], 1'b1, ad[i], {ad[i][15:0], ad[i][31:16]}, 1'b0,
            q, e);
         chk({28'h0, sel_seen}, 32'h1 << (i / 2), "slave sel");
         chk(cap_wd, {ad[i][15:0], ad[i][31:16]}, "wdata");
         chk({31'h0, cap_we}, 32'h1, "write flag");
         bus(~i[0], 1'b0, ad[i], 32'h0, 1'b0, q, e);
         chk(q, ~ad[i], "slave rdata");
      end
      foreach (bad[i]) begin
         bus(i[0], 1'b0, bad[i], 32'h0, 1'b0, q, e);
         chk({31'h0, e}, 32'h1, "unmapped err");
         chk({28'h0, sel_seen}, 32'h0, "unmapped sel");
      end
      $display("t_decode done at %0t", $time);
   endtask

   task automatic t_arb();
      logic [31:0] q0, q1;
      logic e0, e1;
      fork
         bus(0, 1'b0, 32'h0, 32'h0, 1'b0, q0, e0);
         bus(1, 1'b0, 32'h1, 32'h0, 1'b0, q1, e1);
      join
      chk(q0, `SBF_CARD_CHARS, "m0 shared");
      chk(q1, `SBF_SIG_CHARS, "m1 shared");
      fork
         bus(0, 1'b0, 32'h8000_0010, 32'h0, 1'b0, q0, e0);
         bus(1, 1'b0, 32'h8000_0020, 32'h0, 1'b0, q1, e1);
      join
      chk(q0, ~32'h8000_0010, "m0 slow");
      chk(q1, ~32'h8000_0020, "m1 slow");
      $display("t_arb done at %0t", $time);
   endtask

   task automatic t_b2b();
      logic [31:0] q;
      logic e;
      bus(1, 1'b1, 32'h3, 32'h0BAD_F00D, 1'b1, q, e);
      bus(1, 1'b0, 32'h3, 32'h0, 1'b1, q, e);
      chk(q, 32'h0BAD_F00D, "b2b scratch");
      bus(1, 1'b0, 32'h8000_0004, 32'h0, 1'b1, q, e);
      chk(q, ~32'h8000_0004, "b2b slow");
      bus(1, 1'b0, 32'h0400_0008, 32'h0, 1'b0, q, e);
      chk(q, ~32'h0400_0008, "b2b last");
      // a write while the enable is low is acked but must not land
      bus(0, 1'b1, 32'h3, 32'h1234_5678, 1'b1, q, e);
      ce_in <= 1'b0;
      bus(0, 1'b1, 32'h3, 32'hDEAD_BEEF, 1'b0, q, e);
      ce_in <= 1'b1;
      rd(0, 32'h3, 32'h1234_5678, "frozen write");
      $display("t_b2b done at %0t", $time);
   endtask

   // ************************************
   // clock, watchdog, main sequence
   // ************************************
   initial begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end

   initial begin
      #(25 * 5000);
      chk(32'h0, 32'h1, "watchdog");
      end_sim();
   end

   initial begin
      arst_n_in = 1'b0;
      ce_in = 1'b1;
      sel_seen = 4'h0;
      m0_stb_in = 1'b0;
      m0_we_in = 1'b0;
      m1_stb_in = 1'b0;
      m1_we_in = 1'b0;
      m0_addr_in = 32'h0;
      m0_wdata_in = 32'h0;
      m1_addr_in = 32'h0;
      m1_wdata_in = 32'h0;
      ext_flags_in = 32'h1357_9BDF;
      mem_flags_in = 32'h2468_ACE0;
      syn_rx_in = 32'h0F1E_2D3C;
      tw_resp_in = 32'hA5C3_5A3C;
      err_total = 0;
      compares = 0;
      repeat (16) @(posedge clk_in);
      arst_n_in <= 1'b1;
      @(posedge clk_in);
      t_ids();
      t_rw();
      t_decode();
      t_arb();
      t_b2b();
      end_sim();
   end
endmodule
